// ===== crs_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - search writes dummy then three address words; compare only on last
// - match with check bit clear: issue update command 0368H
// - match with check bit set: long data read of associated data first
// - update only when permanent flag zero, else end
// - no match: learn with command 0334H
// - update and learn words come from opcode upper and lower inputs
// - purge: 0619H, long stamp write without compare, 043DH, 0618H
// - add: flag/port word then three address words, no compare, then 0334H
// - delete: search compare sequence then 042DH
// - set address: 0619H, 0220H, address value, 0618H
// - read: 0619H, 0228H, page value, four long segment reads
// - then two medium command reads: status low then high half
// - read ends 0228H, FFFFH, 0618H
// - background-selecting routines end with 0618H
// - successive reads need one set-address; memory auto-increments
module crs_sequencer (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// routine request
	input  wire logic        start,
	input  wire logic [2:0]  routine,
	output logic             ready,
	output logic             done,
	// staged words and configuration
	input  wire logic [15:0] data_w0,
	input  wire logic [15:0] data_w1,
	input  wire logic [15:0] data_w2,
	input  wire logic [15:0] data_w3,
	input  wire logic [7:0]  ext_proc_config,
	input  wire logic [15:0] sa_opcode_upper,
	input  wire logic [15:0] sa_opcode_lower,
	input  wire logic        match_n,
	// results
	output logic [15:0]      rd_seg0,
	output logic [15:0]      rd_seg1,
	output logic [15:0]      rd_seg2,
	output logic [15:0]      rd_seg3,
	output logic [15:0]      status_lo,
	output logic [15:0]      status_hi,
	output logic             matched,
	// memory pins
	output logic             cmd_select_n,
	output logic             write_n,
	output logic             enable_n,
	output logic             compare_latch_n,
	output logic [15:0]      dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in
);
	typedef enum logic [1:0] {
		CRS_IDLE = 2'b00,
		CRS_ISSUE = 2'b01,
		CRS_WAIT = 2'b11
	} crs_state_e;

	crs_state_e   st_r, st_nxt;
	logic [2:0]   rt_r, rt_nxt;
	logic [3:0]   step_r, step_nxt;
	logic [15:0]  seg_r [0:5];
	logic [15:0]  seg_nxt [0:5];
	logic         match_r, match_nxt;
	logic         done_r, done_nxt;
	// current step description
	logic         s_cmd, s_wr, s_cmp, s_last;
	logic [1:0]   s_len;
	logic [15:0]  s_data;
	logic         cyc_start, cyc_done;
	logic [15:0]  cyc_rdata;

	// step table per routine
	always_comb begin
		s_cmd = 1'b0;
		s_wr = 1'b1;
		s_cmp = 1'b0;
		s_len = crs_pkg::LEN_SHORT;
		s_data = crs_pkg::DONT_CARE_WORD;
		s_last = 1'b0;
		unique case (rt_r)
			crs_pkg::CRS_RT_SEARCH, crs_pkg::CRS_RT_DELETE,
			crs_pkg::CRS_RT_ADD: begin
				unique case (step_r)
					4'h0: s_data = (rt_r == crs_pkg::CRS_RT_ADD) ? data_w0
						: crs_pkg::DONT_CARE_WORD;
					4'h1: s_data = data_w1;
					4'h2: s_data = data_w2;
					4'h3: begin
						s_data = data_w3;
						s_cmp = (rt_r != crs_pkg::CRS_RT_ADD);
						s_last = (rt_r == crs_pkg::CRS_RT_ADD) ? 1'b0
							: 1'b0;
					end
					4'h4: begin // associated-data read
						s_wr = 1'b0;
						s_len = crs_pkg::LEN_LONG;
					end
					default: begin
						s_cmd = 1'b1;
						s_len = crs_pkg::LEN_LONG;
						s_last = 1'b1;
						unique case (rt_r)
							crs_pkg::CRS_RT_ADD:
								s_data = crs_pkg::CMD_MOVE_NEXT_FREE;
							crs_pkg::CRS_RT_DELETE:
								s_data = crs_pkg::CMD_SET_HIGH_EMPTY;
							default: s_data = match_r ? sa_opcode_upper
								: sa_opcode_lower;
						endcase
					end
				endcase
			end
			crs_pkg::CRS_RT_PURGE: begin
				unique case (step_r)
					4'h0: begin
						s_cmd = 1'b1;
						s_data = crs_pkg::CMD_SEL_BACKGROUND;
					end
					4'h1: begin
						s_len = crs_pkg::LEN_LONG;
						s_data = data_w0;
					end
					4'h2: begin
						s_cmd = 1'b1;
						s_len = crs_pkg::LEN_LONG;
						s_data = crs_pkg::CMD_SET_ALL_EMPTY;
					end
					default: begin
						s_cmd = 1'b1;
						s_data = crs_pkg::CMD_SEL_FOREGROUND;
						s_last = 1'b1;
					end
				endcase
			end
			crs_pkg::CRS_RT_SETADR: begin
				s_cmd = 1'b1;
				unique case (step_r)
					4'h0: s_data = crs_pkg::CMD_SEL_BACKGROUND;
					4'h1: s_data = crs_pkg::CMD_TARGET_ADDR;
					4'h2: s_data = data_w0;
					default: begin
						s_data = crs_pkg::CMD_SEL_FOREGROUND;
						s_last = 1'b1;
					end
				endcase
			end
			default: begin // read entries
				s_cmd = 1'b1;
				unique case (step_r)
					4'h0: s_data = crs_pkg::CMD_SEL_BACKGROUND;
					4'h1, 4'h9: s_data = crs_pkg::CMD_TARGET_DEVSEL;
					4'h2: s_data = data_w0;
					4'h3, 4'h4, 4'h5, 4'h6: begin
						s_cmd = 1'b0;
						s_wr = 1'b0;
						s_len = crs_pkg::LEN_LONG;
					end
					4'h7, 4'h8: begin
						s_wr = 1'b0;
						s_len = crs_pkg::LEN_MED;
					end
					4'hA: s_data = crs_pkg::SEL_ALL_DEVICES;
					default: begin
						s_data = crs_pkg::CMD_SEL_FOREGROUND;
						s_last = 1'b1;
					end
				endcase
			end
		endcase
	end

	// routine control
	always_comb begin
		st_nxt = st_r;
		rt_nxt = rt_r;
		step_nxt = step_r;
		match_nxt = match_r;
		done_nxt = 1'b0;
		cyc_start = 1'b0;
		for (int i = 0; i < 6; i++) begin
			seg_nxt[i] = seg_r[i];
		end
		unique case (st_r)
			CRS_IDLE: begin
				if (start) begin
					rt_nxt = routine;
					step_nxt = 4'h0;
					st_nxt = CRS_ISSUE;
				end
			end
			CRS_ISSUE: begin
				cyc_start = 1'b1;
				st_nxt = CRS_WAIT;
			end
			CRS_WAIT: begin
				if (cyc_done) begin
					st_nxt = CRS_ISSUE;
					step_nxt = step_r + 4'h1;
					if (rt_r == crs_pkg::CRS_RT_READ && step_r >= 4'h3
						&& step_r <= 4'h8) begin
						seg_nxt[3'(step_r - 4'h3)] = cyc_rdata;
					end
					if (s_last) begin
						st_nxt = CRS_IDLE;
						done_nxt = 1'b1;
					end else if (step_r == 4'h3
						&& rt_r == crs_pkg::CRS_RT_ADD) begin
						step_nxt = 4'h5;
					end else if (step_r == 4'h3
						&& (rt_r == crs_pkg::CRS_RT_SEARCH
						|| rt_r == crs_pkg::CRS_RT_DELETE)) begin
						match_nxt = ~match_n;
						if (rt_r == crs_pkg::CRS_RT_DELETE
							|| !ext_proc_config[crs_pkg::CFG_CHECK_PERM_BIT]
							|| match_n) begin
							step_nxt = 4'h5;
						end
					end else if (step_r == 4'h4
						&& rt_r == crs_pkg::CRS_RT_SEARCH) begin
						if (cyc_rdata[crs_pkg::PERM_FLAG_BIT]) begin
							st_nxt = CRS_IDLE;
							done_nxt = 1'b1;
						end
					end
				end
			end
			default: st_nxt = CRS_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r <= CRS_IDLE;
			rt_r <= 3'h0;
			step_r <= 4'h0;
			match_r <= 1'b0;
			done_r <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				seg_r[i] <= 16'h0000;
			end
		end else begin
			st_r <= st_nxt;
			rt_r <= rt_nxt;
			step_r <= step_nxt;
			match_r <= match_nxt;
			done_r <= done_nxt;
			for (int i = 0; i < 6; i++) begin
				seg_r[i] <= seg_nxt[i];
			end
		end
	end

	// memory bus cycle engine
	crs_bus_cycle u_cycle (
		.clk_sys         (clk_sys),
		.resetn          (resetn),
		.start           (cyc_start),
		.is_cmd          (s_cmd),
		.is_write        (s_wr),
		.compare         (s_cmp),
		.len             (s_len),
		.wdata           (s_data),
		.done            (cyc_done),
		.rdata           (cyc_rdata),
		.cmd_select_n    (cmd_select_n),
		.write_n         (write_n),
		.enable_n        (enable_n),
		.compare_latch_n (compare_latch_n),
		.dq_out          (dq_out),
		.dq_oe           (dq_oe),
		.dq_in           (dq_in)
	);

	assign ready = (st_r == CRS_IDLE);
	assign done = done_r;
	assign matched = match_r;
	assign rd_seg0 = seg_r[0];
	assign rd_seg1 = seg_r[1];
	assign rd_seg2 = seg_r[2];
	assign rd_seg3 = seg_r[3];
	assign status_lo = seg_r[4];
	assign status_hi = seg_r[5];
endmodule

// ===== crs_pkg.sv
package crs_pkg;
	// memory command words
	localparam logic [15:0] CMD_SEL_BACKGROUND = 16'h0619;
	localparam logic [15:0] CMD_SEL_FOREGROUND = 16'h0618;
	localparam logic [15:0] CMD_SET_ALL_EMPTY  = 16'h043D;
	localparam logic [15:0] CMD_SET_HIGH_EMPTY = 16'h042D;
	localparam logic [15:0] CMD_MOVE_NEXT_FREE = 16'h0334;
	localparam logic [15:0] CMD_TARGET_ADDR    = 16'h0220;
	localparam logic [15:0] CMD_TARGET_DEVSEL  = 16'h0228;
	localparam logic [15:0] SEL_ALL_DEVICES    = 16'hFFFF;
	localparam logic [15:0] DONT_CARE_WORD     = 16'h0000;
	// field positions
	localparam int CFG_CHECK_PERM_BIT = 3;
	localparam int PERM_FLAG_BIT      = 15;
	// cycle lengths in system clocks
	localparam logic [1:0] LEN_SHORT = 2'h0;
	localparam logic [1:0] LEN_MED   = 2'h1;
	localparam logic [1:0] LEN_LONG  = 2'h2;
	localparam logic [2:0] CYC_SHORT = 3'h2;
	localparam logic [2:0] CYC_MED   = 3'h3;
	localparam logic [2:0] CYC_LONG  = 3'h4;
	// routine selectors
	typedef enum logic [2:0] {
		CRS_RT_SEARCH = 3'h0,
		CRS_RT_PURGE  = 3'h1,
		CRS_RT_ADD    = 3'h2,
		CRS_RT_DELETE = 3'h3,
		CRS_RT_SETADR = 3'h4,
		CRS_RT_READ   = 3'h5
	} crs_routine_e;
endpackage

// ===== crs_bus_cycle.sv
`timescale 1ns/1ps
// one memory bus cycle: strobe held low for the cycle length
module crs_bus_cycle (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// request
	input  wire logic        start,
	input  wire logic        is_cmd,
	input  wire logic        is_write,
	input  wire logic        compare,
	input  wire logic [1:0]  len,
	input  wire logic [15:0] wdata,
	output logic             done,
	output logic [15:0]      rdata,
	// memory pins
	output logic             cmd_select_n,
	output logic             write_n,
	output logic             enable_n,
	output logic             compare_latch_n,
	output logic [15:0]      dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in
);
	logic [2:0]  cnt_r, cnt_nxt;
	logic        busy_r, busy_nxt;
	logic        cm_r, cm_nxt, w_r, w_nxt, ec_r, ec_nxt, oe_r, oe_nxt;
	logic [15:0] dq_r, dq_nxt, rd_r, rd_nxt;
	logic        done_r, done_nxt;

	// cycle counter and pin levels
	always_comb begin
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		cm_nxt = cm_r;
		w_nxt = w_r;
		ec_nxt = ec_r;
		oe_nxt = oe_r;
		dq_nxt = dq_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		if (!busy_r && start) begin
			busy_nxt = 1'b1;
			cm_nxt = ~is_cmd;
			w_nxt = ~is_write;
			ec_nxt = ~compare;
			oe_nxt = is_write;
			dq_nxt = wdata;
			unique case (len)
				crs_pkg::LEN_SHORT: cnt_nxt = crs_pkg::CYC_SHORT;
				crs_pkg::LEN_MED:   cnt_nxt = crs_pkg::CYC_MED;
				default:            cnt_nxt = crs_pkg::CYC_LONG;
			endcase
		end else if (busy_r) begin
			cnt_nxt = cnt_r - 3'h1;
			if (cnt_r == 3'h1) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				rd_nxt = dq_in; // sample at end of strobe
				cm_nxt = 1'b1;
				w_nxt = 1'b1;
				ec_nxt = 1'b1;
				oe_nxt = 1'b0;
			end
		end
	end

	// registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 3'h0;
			busy_r <= 1'b0;
			cm_r <= 1'b1;
			w_r <= 1'b1;
			ec_r <= 1'b1;
			oe_r <= 1'b0;
			dq_r <= 16'h0000;
			rd_r <= 16'h0000;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			cm_r <= cm_nxt;
			w_r <= w_nxt;
			ec_r <= ec_nxt;
			oe_r <= oe_nxt;
			dq_r <= dq_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign rdata = rd_r;
	assign cmd_select_n = cm_r;
	assign write_n = w_r;
	assign enable_n = ~busy_r;
	assign compare_latch_n = ec_r;
	assign dq_out = dq_r;
	assign dq_oe = oe_r;
endmodule

// ===== crs_seq_props.sv
`timescale 1ns/1ps
// bus timing checks at the sequencer pins
module crs_seq_props (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        resetn,
	// request
	input wire logic        start,
	input wire logic        ready,
	input wire logic        done,
	// memory pins
	input wire logic        cmd_select_n,
	input wire logic        write_n,
	input wire logic        enable_n,
	input wire logic        compare_latch_n,
	input wire logic [15:0] dq_out,
	input wire logic        dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// strobe lengths per cycle kind
	property p_len;
		$fell(enable_n) |-> ##[2:4] $rose(enable_n);
	endproperty
	a_len: assert property (p_len) else $error("strobe len");
	property p_dread;
		$fell(enable_n) && write_n && cmd_select_n |-> ##4 $rose(enable_n);
	endproperty
	a_dread: assert property (p_dread) else $error("read len");
	property p_cread;
		$fell(enable_n) && write_n && !cmd_select_n |-> ##3 $rose(enable_n);
	endproperty
	a_cread: assert property (p_cread) else $error("cmd rd len");
	// compare only on a short data write
	property p_cmp;
		$fell(compare_latch_n) |-> !enable_n && cmd_select_n && !write_n
			##2 $rose(compare_latch_n) && $rose(enable_n);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare");
	// bus drive follows direction and stands
	property p_oe;
		!enable_n |-> dq_oe == !write_n;
	endproperty
	a_oe: assert property (p_oe) else $error("drive dir");
	property p_hold;
		!enable_n && !$past(enable_n) |-> $stable({cmd_select_n, write_n, dq_out});
	endproperty
	a_hold: assert property (p_hold) else $error("pins moved");
	// one routine at a time
	property p_idle;
		ready |-> enable_n && !dq_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("idle bus");
	property p_take;
		start && ready |=> !ready;
	endproperty
	a_take: assert property (p_take) else $error("not taken");
	property p_done;
		done |-> enable_n ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("done pulse");
	// main scenarios seen
	c_cmp: cover property ($fell(compare_latch_n));
	c_crd: cover property ($fell(enable_n) && write_n && !cmd_select_n);
	c_done: cover property (done);
endmodule
bind crs_sequencer crs_seq_props i_props (.clk_sys, .resetn, .start,
	.ready, .done, .cmd_select_n, .write_n, .enable_n, .compare_latch_n,
	.dq_out, .dq_oe);

// ===== crs_cam_model.sv
`timescale 1ns/1ps
// memory stand-in: logs each bus cycle and answers reads
module crs_cam_model (
	// clock
	input wire logic         clk_sys,
	// memory pins
	input wire logic         cmd_select_n,
	input wire logic         write_n,
	input wire logic         enable_n,
	input wire logic         compare_latch_n,
	input wire logic [15:0]  dq_out,
	input wire logic         dq_oe,
	output logic [15:0]      dq_in,
	output logic             match_n,
	// scenario controls
	input wire logic         hit,
	input wire logic         clr,
	input wire logic [15:0]  rbase
);
	logic [21:0] lg[$];
	logic [2:0]  cnt;
	logic [18:0] cur;
	logic [7:0]  nrd;
	logic [15:0] last;
	// match result as the scenario commands; idle bus never holds a value
	assign match_n = !hit;
	assign dq_in = (!enable_n && write_n) ? rbase + 16'(nrd) : ~last;
	// count strobe clocks, log the cycle once the strobe ends
	always @(posedge clk_sys) begin
		last <= dq_in;
		if (clr) begin
			lg = {};
			cnt <= 3'h0;
			nrd <= 8'h00;
		end else if (!enable_n) begin
			cnt <= cnt + 3'h1;
			cur <= {cmd_select_n, write_n, compare_latch_n,
				dq_oe ? dq_out : 16'h0000};
		end else if (cnt != 3'h0) begin
			lg.push_back({cnt, cur});
			cnt <= 3'h0;
			if (cur[17])
				nrd <= nrd + 8'h01;
		end
	end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
	logic        clk_sys, resetn, start, hit, clr;
	logic        ready, done, matched, cm, wr, en, ec, oe, mn;
	logic [2:0]  routine;
	logic [7:0]  cfg;
	logic [15:0] w0, w1, w2, w3, up, lo, rbase, dqo, dqi;
	logic [15:0] s0, s1, s2, s3, sl, sh;
	logic [21:0] exp[$];
	int          errors, n_compared;
	crs_sequencer i_dut (.clk_sys, .resetn, .start, .routine, .ready,
		.done, .data_w0(w0), .data_w1(w1), .data_w2(w2), .data_w3(w3),
		.ext_proc_config(cfg), .sa_opcode_upper(up), .sa_opcode_lower(lo),
		.match_n(mn), .rd_seg0(s0), .rd_seg1(s1), .rd_seg2(s2),
		.rd_seg3(s3), .status_lo(sl), .status_hi(sh), .matched,
		.cmd_select_n(cm), .write_n(wr), .enable_n(en),
		.compare_latch_n(ec), .dq_out(dqo), .dq_oe(oe), .dq_in(dqi));
	crs_cam_model i_cam (.clk_sys, .cmd_select_n(cm), .write_n(wr),
		.enable_n(en), .compare_latch_n(ec), .dq_out(dqo), .dq_oe(oe),
		.dq_in(dqi), .match_n(mn), .hit, .clr, .rbase);
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// expected cycle: length, {cmd_n, write_n, cmp_n}, word
	task automatic q(input logic [2:0] l, input logic [2:0] p,
		input logic [15:0] d);
		exp.push_back({l, p, d});
	endtask
	task automatic rst();
		@(negedge clk_sys);
		resetn = 1'b0;
		clr = 1'b1;
		repeat (3) @(negedge clk_sys);
		resetn = 1'b1;
		clr = 1'b0;
		exp = {};
	endtask
	// start a routine, optionally poke start while busy, await done
	task automatic run(input logic [2:0] r, input logic b);
		int k;
		routine = r;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		if (b) begin
			repeat (4) @(negedge clk_sys);
			routine = 3'h2;
			start = 1'b1;
			@(negedge clk_sys);
			start = 1'b0;
		end
		for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk_sys);
		`CHK(done, 1'b1)
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic chk();
		`CHK(i_cam.lg.size(), exp.size())
		foreach (exp[i])
			if (i < i_cam.lg.size()) `CHK(i_cam.lg[i], exp[i])
	endtask
	// four segment writes, last one optionally with compare
	task automatic sw(input logic [15:0] f, input logic c);
		q(2, 5, f);
		q(2, 5, w1);
		q(2, 5, w2);
		q(2, {2'b10, c}, w3);
	endtask
	task automatic t_search(input logic h, input logic b, input logic p);
		rst();
		hit = h;
		cfg = {4'h0, b, 3'h0};
		rbase = {p, 15'h1234};
		sw(16'h0000, 1'b0);
		if (h && b) q(4, 7, 16'h0000);
		if (!h) q(4, 1, lo);
		else if (!(b && p)) q(4, 1, up);
		run(3'h0, 1'b0);
		chk();
		`CHK(matched, h)
	endtask
	task automatic t_misc();
		rst();
		w0 = 16'h00A5;
		q(2, 1, 16'h0619);
		q(4, 5, w0);
		q(4, 1, 16'h043D);
		q(2, 1, 16'h0618);
		run(3'h1, 1'b1);
		chk();
		rst();
		w0 = 16'h9500;
		sw(w0, 1'b1);
		q(4, 1, 16'h0334);
		run(3'h2, 1'b0);
		chk();
		rst();
		hit = 1'b1;
		sw(16'h0000, 1'b0);
		q(4, 1, 16'h042D);
		run(3'h3, 1'b0);
		chk();
		rst();
		w0 = 16'h0123;
		q(2, 1, 16'h0619);
		q(2, 1, 16'h0220);
		q(2, 1, w0);
		q(2, 1, 16'h0618);
		run(3'h4, 1'b0);
		chk();
	endtask
	// two reads back to back, no address set in between
	task automatic t_read();
		int k;
		rst();
		w0 = 16'h0042;
		rbase = 16'hBC00; // bit 15 set: reads must not end the routine
		for (k = 0; k < 12; k += 6) begin
			q(2, 1, 16'h0619);
			q(2, 1, 16'h0228);
			q(2, 1, w0);
			repeat (4) q(4, 7, 16'h0000);
			repeat (2) q(3, 3, 16'h0000);
			q(2, 1, 16'h0228);
			q(2, 1, 16'hFFFF);
			q(2, 1, 16'h0618);
			run(3'h5, 1'b0);
			`CHK({s0, s1, s2, s3}, {rbase + 16'(k), rbase + 16'(k + 1),
				rbase + 16'(k + 2), rbase + 16'(k + 3)})
			`CHK({sl, sh}, {rbase + 16'(k + 4), rbase + 16'(k + 5)})
		end
		chk();
	endtask
	task automatic results();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial begin
		resetn = 1'b0;
		clr = 1'b1;
		start = 1'b0;
		hit = 1'b0;
		routine = 3'h0;
		cfg = 8'h00;
		rbase = 16'h0000;
		{w0, w1, w2, w3} = {16'h0000, 16'hA1B2, 16'hC3D4, 16'hE5F6};
		up = 16'h5A68;
		lo = 16'h5A34;
		t_search(1'b0, 1'b0, 1'b0);
		t_search(1'b1, 1'b0, 1'b0);
		t_search(1'b1, 1'b1, 1'b0);
		t_search(1'b1, 1'b1, 1'b1);
		t_search(1'b0, 1'b1, 1'b0);
		t_misc();
		t_read();
		results();
	end
	// watchdog
	initial begin
		#200000;
		errors++;
		results();
	end
endmodule
